// *** verilog/dpsc_pkg.sv ***
// constants for the digipot serial command core
package dpsc_pkg;
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned WIPER_BITS  = 6;
  localparam int unsigned NV_LOCS     = 16;
  localparam int unsigned CHANNELS    = 4;
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned SAVE_MS     = 25;
  localparam int unsigned SAVE_CYCLES = SAVE_MS * 1000 * CLK_MHZ;
  localparam logic [5:0]  WIPER_MID   = 6'h20;
  localparam logic [5:0]  WIPER_MAX   = 6'h3f;
  localparam logic [5:0]  WIPER_ZERO  = 6'h00;
  localparam logic [7:0]  NV_USER_RST = 8'hff;
  localparam logic [4:0]  BIT_CNT_TOP = 5'h10;
  localparam logic [3:0] CMD_NOP      = 4'h0;
  localparam logic [3:0] CMD_RESTORE  = 4'h1;
  localparam logic [3:0] CMD_SAVE     = 4'h2;
  localparam logic [3:0] CMD_STORE    = 4'h3;
  localparam logic [3:0] CMD_SHR_ONE  = 4'h4;
  localparam logic [3:0] CMD_SHR_ALL  = 4'h5;
  localparam logic [3:0] CMD_DEC_ONE  = 4'h6;
  localparam logic [3:0] CMD_DEC_ALL  = 4'h7;
  localparam logic [3:0] CMD_RELOAD   = 4'h8;
  localparam logic [3:0] CMD_RD_NV    = 4'h9;
  localparam logic [3:0] CMD_RD_WIPER = 4'ha;
  localparam logic [3:0] CMD_WRITE    = 4'hb;
  localparam logic [3:0] CMD_SHL_ONE  = 4'hc;
  localparam logic [3:0] CMD_SHL_ALL  = 4'hd;
  localparam logic [3:0] CMD_INC_ONE  = 4'he;
  localparam logic [3:0] CMD_INC_ALL  = 4'hf;
  typedef enum logic [2:0] {
    DPSC_IDLE  = 3'b001,
    DPSC_POWER = 3'b010,
    DPSC_SAVE  = 3'b100
  } dpsc_state_t;
endpackage : dpsc_pkg

// *** verilog/dpsc_core.sv ***
// serial command core of a four-channel 64-position nonvolatile digipot
// How it works
// R1 - zero is B end, all ones A end
// R2 - wiper registers rewrite freely, no endurance limit
// R3 - code 11 loads data into addressed wiper
// R4 - code 2 saves wiper, done after 25 ms
// R5 - power-on reloads wipers; factory store is midscale
// R6 - preset low forces midscale, rise reloads store
// R7 - later strobes repeat step and shift commands
// R8 - write-protect low blocks changes except reloads; the core also blocks the code 1 restore
// R9 - host sends no-op before releasing write-protect
// R10 - sixteen-bit words, most significant bit first
// R11 - host holds select low; execute on rise
// R12 - command, address nibble, then data byte
// R13 - host ends activity with a no-op
// R14 - serial output released while select high
// R15 - works in SPI modes 0 and 3
// R16 - codes 10 and 9 read back
// R17 - other codes forward bits for chaining
// R18 - host shifts 32 bits for two devices
// R19 - code 1 restores one, 8 all wipers
// R20 - code 3 stores data byte in store
// R21 - codes 4-7 halve or decrement, one/all
// R22 - codes 12-15 double or increment, one/all
// R23 - input sampled on serial clock rising edge
// R24 - forwarded output lags input by 16 clocks
// R25 - shifter locked during save; ready marks done
// R26 - wiper steps saturate, never wrap
`timescale 1ns/10ps
module dpsc_core #(
  parameter int unsigned SAVE_CYCLES = dpsc_pkg::SAVE_CYCLES
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_sclk,
  input  wire logic        i_sdi,
  input  wire logic        i_cs_b,
  input  wire logic        i_wp_b,
  input  wire logic        i_preset_b,
  output logic             o_sdo,
  output logic             o_sdo_oe_b,
  output logic             o_ready,
  output logic             o_low_power,
  output logic [5:0]       o_wiper0,
  output logic [5:0]       o_wiper1,
  output logic [5:0]       o_wiper2,
  output logic [5:0]       o_wiper3
);
  // pin synchronisers: first stage feeds only the second
  logic [1:0] sclk_s_ff;
  logic [1:0] sdi_s_ff;  // same depth as sclk, so data lines up with the detected edge
  logic [1:0] cs_s_ff;
  logic [1:0] wp_s_ff;
  logic [1:0] pr_s_ff;
  logic       sclk_d_ff;
  logic       cs_d_ff;
  logic       pr_d_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_s_ff <= 2'h0;
      sdi_s_ff  <= 2'h0;
      cs_s_ff   <= 2'h3;
      wp_s_ff   <= 2'h3;
      pr_s_ff   <= 2'h3;
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
      pr_d_ff   <= 1'b1;
    end else begin
      sclk_s_ff <= {sclk_s_ff[0], i_sclk};
      sdi_s_ff  <= {sdi_s_ff[0], i_sdi};
      cs_s_ff   <= {cs_s_ff[0], i_cs_b};
      wp_s_ff   <= {wp_s_ff[0], i_wp_b};
      pr_s_ff   <= {pr_s_ff[0], i_preset_b};
      sclk_d_ff <= sclk_s_ff[1];
      cs_d_ff   <= cs_s_ff[1];
      pr_d_ff   <= pr_s_ff[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_low;
  logic pr_low;
  logic pr_rise;
  logic wp_low;
  assign sclk_rise = sclk_s_ff[1] & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s_ff[1] & sclk_d_ff;
  assign cs_low    = ~cs_s_ff[1];
  assign cs_rise   = cs_s_ff[1] & ~cs_d_ff;
  assign pr_low    = ~pr_s_ff[1];
  assign pr_rise   = pr_s_ff[1] & ~pr_d_ff;
  assign wp_low    = ~wp_s_ff[1];

  dpsc_pkg::dpsc_state_t state_ff;
  logic                  locked;
  assign locked = (state_ff == dpsc_pkg::DPSC_SAVE);
  // a strobe that lands while saving is dropped; hosts must wait for ready

  // shift register and output path
  logic [15:0] shift_ff;
  logic [15:0] cmd_ff;
  logic        cmd_valid_ff;
  logic        sdo_ff;
  logic [4:0]  bit_cnt_ff;
  logic [3:0]  op;
  logic [3:0]  loc;
  logic [1:0]  ch;
  logic [7:0]  payload;
  assign op      = cmd_ff[15:12];
  assign loc     = cmd_ff[11:8];
  assign ch      = cmd_ff[9:8];
  assign payload = cmd_ff[7:0];

  // codes 4-7 and 12-15 step or shift; the odd ones among them act on all channels
  logic        step_cmd;
  logic        all_ch;
  assign step_cmd = op[2];
  assign all_ch   = op[0];

  logic        fresh_word;
  assign fresh_word = (bit_cnt_ff != 5'h0);

  logic [7:0] nv_ff [dpsc_pkg::NV_LOCS];
  logic [5:0] wiper_ff [dpsc_pkg::CHANNELS];

  // readback data loaded on the decoding strobe
  logic [15:0] rd_word;
  always_comb begin
    rd_word = shift_ff;
    if (shift_ff[15:12] == dpsc_pkg::CMD_RD_NV) begin // see R16
      rd_word = {shift_ff[15:8], nv_ff[shift_ff[11:8]]};
    end else if (shift_ff[15:12] == dpsc_pkg::CMD_RD_WIPER) begin // see R16
      rd_word = {shift_ff[15:8], 2'h0, wiper_ff[shift_ff[9:8]]};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_ff     <= 16'h0;
      bit_cnt_ff   <= 5'h0;
      sdo_ff       <= 1'b1;
    end else if (cs_low && !locked) begin // see R11 see R25
      if (sclk_rise) begin
        shift_ff <= {shift_ff[14:0], sdi_s_ff[1]}; // see R10 see R23
        if (bit_cnt_ff != dpsc_pkg::BIT_CNT_TOP) begin
          bit_cnt_ff <= bit_cnt_ff + 5'h1;
        end
      end else if (sclk_fall) begin
        // msb changes on falling edge, valid before the next rise (modes 0 and 3)
        sdo_ff <= shift_ff[15]; // see R15 see R17 see R24
      end
    end else if (cs_rise && !locked) begin
      bit_cnt_ff <= 5'h0;
      if (fresh_word) begin
        shift_ff     <= rd_word;
        sdo_ff       <= rd_word[15];
      end
    end
  end

  assign o_sdo      = sdo_ff;
  assign o_sdo_oe_b = ~cs_low | sdo_ff; // open drain: only pulls low, see R14

  // latch the command on the strobe; an empty strobe repeats a step or shift command
  logic exec;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_ff       <= 16'h0;
      cmd_valid_ff <= 1'b0;
    end else if (cs_rise && !locked) begin
      if (fresh_word) begin
        cmd_ff       <= shift_ff;
        cmd_valid_ff <= 1'b1;
      end else begin
        // only step and shift commands are repeatable
        cmd_valid_ff <= step_cmd; // see R7
      end
    end else begin
      cmd_valid_ff <= 1'b0;
    end
  end
  assign exec = cmd_valid_ff;

  // state: power-on reload, idle, save
  logic [$clog2(dpsc_pkg::SAVE_CYCLES+1)-1:0] save_cnt_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff    <= dpsc_pkg::DPSC_POWER;
      save_cnt_ff <= '0;
    end else begin
      case (state_ff)
        dpsc_pkg::DPSC_POWER: begin
          // one reload cycle after reset; ready stays low meanwhile
          state_ff <= dpsc_pkg::DPSC_IDLE;
        end
        dpsc_pkg::DPSC_IDLE: begin
          if (exec && !wp_low &&
              (op == dpsc_pkg::CMD_SAVE || op == dpsc_pkg::CMD_STORE)) begin
            state_ff    <= dpsc_pkg::DPSC_SAVE; // see R4 see R25
            save_cnt_ff <= '0;
          end
        end
        dpsc_pkg::DPSC_SAVE: begin
          if (save_cnt_ff >= ($bits(save_cnt_ff))'(SAVE_CYCLES - 1)) begin
            state_ff <= dpsc_pkg::DPSC_IDLE; // see R4
          end else begin
            save_cnt_ff <= save_cnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= dpsc_pkg::DPSC_IDLE;
        end
      endcase
    end
  end
  assign o_ready = (state_ff == dpsc_pkg::DPSC_IDLE); // see R25

  // nonvolatile store; reset stands in for factory content
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < dpsc_pkg::NV_LOCS; i++) begin
        nv_ff[i] <= (i < dpsc_pkg::CHANNELS) ? {2'h0, dpsc_pkg::WIPER_MID}
                                            : dpsc_pkg::NV_USER_RST; // see R5
      end
    end else if (exec && !wp_low && state_ff == dpsc_pkg::DPSC_IDLE) begin
      if (op == dpsc_pkg::CMD_SAVE) begin
        nv_ff[{2'h0, ch}] <= {2'h0, wiper_ff[ch]}; // see R4
      end else if (op == dpsc_pkg::CMD_STORE) begin
        nv_ff[loc] <= payload; // see R20 see R12
      end
    end
  end

  // wiper arithmetic with saturation
  function automatic logic [5:0] dpsc_step(input logic [5:0] w, input logic [3:0] c);
    logic [5:0] r;
    r = w;
    case (c)
      dpsc_pkg::CMD_SHR_ONE, dpsc_pkg::CMD_SHR_ALL: r = w >> 1; // see R21
      dpsc_pkg::CMD_DEC_ONE, dpsc_pkg::CMD_DEC_ALL:
        r = (w == dpsc_pkg::WIPER_ZERO) ? w : w - 6'h1; // see R21 see R26
      dpsc_pkg::CMD_SHL_ONE, dpsc_pkg::CMD_SHL_ALL:
        // zero doubles to one, top bit set saturates to full scale
        r = (w == dpsc_pkg::WIPER_ZERO) ? 6'h01 :
            (w[5] ? dpsc_pkg::WIPER_MAX : {w[4:0], 1'b1}); // see R22 see R26
      dpsc_pkg::CMD_INC_ONE, dpsc_pkg::CMD_INC_ALL:
        r = (w == dpsc_pkg::WIPER_MAX) ? w : w + 6'h1; // see R22 see R26
      default: r = w;
    endcase
    return r;
  endfunction : dpsc_step

  // wiper registers: plain flops, unlimited rewrites (see R2)
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < dpsc_pkg::CHANNELS; i++) begin
        wiper_ff[i] <= dpsc_pkg::WIPER_MID;
      end
    end else begin
      for (int i = 0; i < dpsc_pkg::CHANNELS; i++) begin
        // preset outranks every serial command, reloads included
        if (pr_low) begin
          wiper_ff[i] <= dpsc_pkg::WIPER_MID; // see R6
        end else if (pr_rise || state_ff == dpsc_pkg::DPSC_POWER) begin
          wiper_ff[i] <= nv_ff[i][5:0]; // see R5 see R6 see R8
        end else if (exec) begin
          if (op == dpsc_pkg::CMD_RELOAD) begin
            wiper_ff[i] <= nv_ff[i][5:0]; // see R19 see R8
          end else if (!wp_low) begin // see R8
            if (op == dpsc_pkg::CMD_RESTORE && ch == 2'(i)) begin
              wiper_ff[i] <= nv_ff[i][5:0]; // see R19
            end else if (op == dpsc_pkg::CMD_WRITE && ch == 2'(i)) begin
              wiper_ff[i] <= payload[5:0]; // see R3 see R12
            end else if (step_cmd && (all_ch || ch == 2'(i))) begin
              wiper_ff[i] <= dpsc_step(wiper_ff[i], op); // see R7
            end
          end
        end
      end
    end
  end

  // code 0 is b end, all ones a end
  assign o_wiper0 = wiper_ff[0]; // see R1
  assign o_wiper1 = wiper_ff[1];
  assign o_wiper2 = wiper_ff[2];
  assign o_wiper3 = wiper_ff[3];

  // low-power indicator follows the last executed command (see R13)
  logic low_power_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_power_ff <= 1'b1;
    end else if (exec) begin
      low_power_ff <= (op == dpsc_pkg::CMD_NOP);
    end
  end
  assign o_low_power = low_power_ff;

endmodule : dpsc_core

// *** tb/dpsc_core_chk.sv ***
// pin-level assertions for the digipot serial command core
`timescale 1ns/10ps
module dpsc_core_chk #(
  parameter int unsigned SAVE_CYCLES = 20
) (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_b,
  input wire logic       i_sclk,
  input wire logic       i_sdi,
  input wire logic       i_cs_b,
  input wire logic       i_wp_b,
  input wire logic       i_preset_b,
  input wire logic       o_sdo,
  input wire logic       o_sdo_oe_b,
  input wire logic       o_ready,
  input wire logic       o_low_power,
  input wire logic [5:0] o_wiper0,
  input wire logic [5:0] o_wiper1,
  input wire logic [5:0] o_wiper2,
  input wire logic [5:0] o_wiper3
);
  localparam int SAVE_LIM = SAVE_CYCLES + 8;
  logic [23:0] wip;
  assign wip = {o_wiper0, o_wiper1, o_wiper2, o_wiper3};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  property p_sdo_off; i_cs_b [*4] |-> o_sdo_oe_b; endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo driven while deselected");
  property p_boot; $rose(i_rst_b) |-> ##[0:3] o_ready; endproperty
  a_boot: assert property (p_boot) else $error("ready late after reset");
  property p_pr_mid; $fell(i_preset_b) |-> ##[1:8] wip == {4{dpsc_pkg::WIPER_MID}}; endproperty
  a_pr_mid: assert property (p_pr_mid) else $error("preset did not force midscale");
  property p_pr_hold; (!i_preset_b) [*8] |-> wip == {4{dpsc_pkg::WIPER_MID}}; endproperty
  a_pr_hold: assert property (p_pr_hold) else $error("midscale not held");
  property p_cs_low; (!i_cs_b && i_preset_b) [*8] |-> $stable(wip); endproperty
  a_cs_low: assert property (p_cs_low) else $error("wiper moved inside frame");
  property p_save_min; $fell(o_ready) |-> (!o_ready) [*8]; endproperty
  a_save_min: assert property (p_save_min) else $error("save too short");
  property p_save_end; $fell(o_ready) |-> ##[1:SAVE_LIM] o_ready; endproperty
  a_save_end: assert property (p_save_end) else $error("save never ended");
  property p_save_lock; !o_ready && $past(!o_ready) && i_preset_b |-> $stable(wip); endproperty
  a_save_lock: assert property (p_save_lock) else $error("wiper moved during save");
  c_save: cover property ($fell(o_ready));
  c_preset: cover property ($fell(i_preset_b));
  c_sdo_low: cover property (!o_sdo_oe_b);
endmodule : dpsc_core_chk
bind dpsc_core dpsc_core_chk #(.SAVE_CYCLES(SAVE_CYCLES)) i_chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_sdi(i_sdi), .i_cs_b(i_cs_b),
  .i_wp_b(i_wp_b), .i_preset_b(i_preset_b), .o_sdo(o_sdo), .o_sdo_oe_b(o_sdo_oe_b),
  .o_ready(o_ready), .o_low_power(o_low_power), .o_wiper0(o_wiper0), .o_wiper1(o_wiper1),
  .o_wiper2(o_wiper2), .o_wiper3(o_wiper3));

// *** tb/dpsc_host.sv ***
// host model: spi master on the serial pins, modes 0 and 3
`timescale 1ns/10ps
module dpsc_host (
  output logic      o_sclk,
  output logic      o_sdi,
  output logic      o_cs_b,
  input  wire logic i_sdo_w
);
  logic cpol = 1'b0;
  initial begin
    o_sclk = 1'b0;
    o_sdi  = 1'b1;
    o_cs_b = 1'b1;
  end
  // clock parks at its idle level; it never runs outside a frame
  task automatic sel(input logic lvl);
    o_sclk = cpol;
    #40 o_cs_b = lvl;
    #40;
  endtask : sel
  task automatic shift16(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      o_sdi = w[i];
      if (cpol) o_sclk = 1'b0;
      #32 o_sclk = 1'b1;
      r[i] = i_sdo_w;
      #32 o_sclk = cpol;
    end
    // released data line shows the inverse so a stale bit cannot pass
    o_sdi = ~w[0];
  endtask : shift16
endmodule : dpsc_host

// *** tb/dpsc_core_test.sv ***
// self-checking bench for the digipot serial command core
`timescale 1ns/10ps
module dpsc_core_test;
  logic        i_clk_sys, i_rst_b, i_wp_b, i_preset_b, sclk, sdi, cs_b, sdo_w;
  logic        o_sdo, o_sdo_oe_b, o_ready, o_low_power;
  logic [5:0]  o_wiper0, o_wiper1, o_wiper2, o_wiper3;
  logic [23:0] wp4;
  logic [15:0] rd;
  int          err_count = 0;
  int          comparisons = 0;
  assign wp4 = {o_wiper0, o_wiper1, o_wiper2, o_wiper3};
  assign sdo_w = o_sdo_oe_b ? 1'b1 : o_sdo;
  dpsc_core #(.SAVE_CYCLES(20)) i_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_sclk(sclk), .i_sdi(sdi), .i_cs_b(cs_b), .i_wp_b(i_wp_b), .i_preset_b(i_preset_b),
    .o_sdo(o_sdo), .o_sdo_oe_b(o_sdo_oe_b), .o_ready(o_ready), .o_low_power(o_low_power),
    .o_wiper0(o_wiper0), .o_wiper1(o_wiper1), .o_wiper2(o_wiper2), .o_wiper3(o_wiper3));
  dpsc_host i_host (.o_sclk(sclk), .o_sdi(sdi), .o_cs_b(cs_b), .i_sdo_w(sdo_w));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc
  task automatic strobe;
    i_host.sel(1'b0);
    i_host.sel(1'b1);
    cyc(10);
  endtask : strobe
  task automatic word(input logic [15:0] w);
    i_host.sel(1'b0);
    i_host.shift16(w, rd);
    i_host.sel(1'b1);
    cyc(10);
  endtask : word
  task automatic wait_ready;
    for (int i = 0; i < 100 && o_ready !== 1'b1; i++) cyc(1);
  endtask : wait_ready
  task automatic t_write_read;
    word(16'hb110);
    cmp(wp4, {6'h20, 6'h10, 6'h20, 6'h20});
    word(16'ha100);
    word(16'h0abc);
    cmp({8'h00, rd}, 24'h00a110);
    word(16'h0000);
    cmp({8'h00, rd}, 24'h000abc);
    cmp({23'h0, o_low_power}, 24'h1);
  endtask : t_write_read
  task automatic t_steps;
    word(16'hb003);
    word(16'h6000);
    strobe();
    cmp(wp4, {6'h01, 6'h10, 6'h20, 6'h20});
    strobe();
    strobe();
    cmp(wp4, {6'h00, 6'h10, 6'h20, 6'h20});
    word(16'hf000);
    cmp(wp4, {6'h01, 6'h11, 6'h21, 6'h21});
    word(16'hc000);
    cmp(wp4, {6'h03, 6'h11, 6'h21, 6'h21});
    word(16'h5000);
    cmp(wp4, {6'h01, 6'h08, 6'h10, 6'h10});
  endtask : t_steps
  task automatic t_save;
    word(16'hb205);
    word(16'h2200);
    cmp({23'h0, o_ready}, 24'h0);
    wait_ready();
    cmp({23'h0, o_ready}, 24'h1);
    i_preset_b = 1'b0;
    cyc(10);
    cmp(wp4, {4{6'h20}});
    i_preset_b = 1'b1;
    cyc(10);
    cmp(wp4, {6'h20, 6'h20, 6'h05, 6'h20});
  endtask : t_save
  task automatic t_protect;
    word(16'hb111);
    i_wp_b = 1'b0;
    word(16'hb33f);
    word(16'hf000);
    word(16'h2100);
    cmp({23'h0, o_ready}, 24'h1);
    cmp(wp4, {6'h20, 6'h11, 6'h05, 6'h20});
    word(16'h8000);
    cmp(wp4, {6'h20, 6'h20, 6'h05, 6'h20});
    word(16'h0000);
    i_wp_b = 1'b1;
  endtask : t_protect
  task automatic t_mode3_chain;
    i_host.cpol = 1'b1;
    word(16'hb10a);
    cmp(wp4, {6'h20, 6'h0a, 6'h05, 6'h20});
    i_host.sel(1'b0);
    i_host.shift16(16'hb13c, rd);
    i_host.shift16(16'hb307, rd);
    i_host.sel(1'b1);
    cyc(10);
    cmp(wp4, {6'h20, 6'h0a, 6'h05, 6'h07});
    cmp({8'h00, rd}, 24'h00b13c);
  endtask : t_mode3_chain
  task automatic t_nv;
    i_host.cpol = 1'b0;
    word(16'h35a5);
    cmp({23'h0, o_ready}, 24'h0);
    wait_ready();
    word(16'h3017);
    wait_ready();
    word(16'h9500);
    word(16'h1000);
    cmp({8'h00, rd}, 24'h0095a5);
    cmp(wp4, {6'h17, 6'h0a, 6'h05, 6'h07});
    word(16'h4000);
    cmp(wp4, {6'h0b, 6'h0a, 6'h05, 6'h07});
    word(16'h7000);
    cmp(wp4, {6'h0a, 6'h09, 6'h04, 6'h06});
    word(16'hd000);
    cmp(wp4, {6'h15, 6'h13, 6'h09, 6'h0d});
    word(16'hb13f);
    word(16'hc100);
    word(16'he100);
    cmp(wp4, {6'h15, 6'h3f, 6'h09, 6'h0d});
    word(16'he300);
    cmp(wp4, {6'h15, 6'h3f, 6'h09, 6'h0e});
    word(16'h0000);
  endtask : t_nv
  task automatic print_verdict;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    i_rst_b = 1'b0;
    i_wp_b = 1'b1;
    i_preset_b = 1'b1;
    cyc(2);
    i_rst_b = 1'b1;
    cyc(4);
    cmp(wp4, {4{6'h20}});
    t_write_read();
    t_steps();
    t_save();
    t_protect();
    t_mode3_chain();
    t_nv();
    print_verdict();
  end
endmodule : dpsc_core_test
